//--- pkg/pin_select_defs.svh
// Constants for the port D pin function select block
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

`define PDSEL_ADDR_SELECT 12'h000
`define PDSEL_ADDR_VARIANT 12'h004
`define PDSEL_SELECT_RESET 8'hff
`define PDSEL_VARIANT_RESET 2'h0
`define PDSEL_AXI_OKAY 2'h0
`define PDSEL_AXI_DECERR 2'h3
`define PDSEL_PINS 8
`define PDSEL_VAR_FULL 2'h0
`define PDSEL_VAR_SMALL 2'h1
`define PDSEL_VAR_MID 2'h2
`define PDSEL_VAR_LARGE 2'h3

`endif

//--- pkg/pin_select_pkg.sv
// Types shared by the port D pin function select block
package pin_select_pkg;

    // Device variant, which decides the sharing of timer signals
    typedef enum logic [1:0] {
        variant_full = 2'h0,
        variant_small = 2'h1,
        variant_mid = 2'h2,
        variant_large = 2'h3
    } variant_t;

    // Timer and interrupt signals that may share a port D pin
    typedef struct packed {
        logic periodic_timer1_inverted_output;
        logic periodic_timer1_output;
        logic periodic_timer0_inverted_output;
        logic periodic_timer0_output;
        logic compact_timer2_output;
    } timer_out_t;

    typedef struct packed {
        logic periodic_timer0_clock_input;
        logic standard_timer_clock_input;
        logic compact_timer_clock_input;
        logic external_interrupt1_input;
        logic periodic_timer1_clock_input;
    } timer_in_t;

    // Write response state, one-hot
    typedef enum logic [1:0] {
        wr_idle = 2'b01,
        wr_resp = 2'b10
    } wr_state_t;

endpackage

//--- design/pin_route.sv
// One port D pin: output choice and input gating
`timescale 1ns/1ps
`default_nettype none

module pin_route
(
    input wire logic select_bit,
    input wire logic seg_value,
    input wire logic timer_value,
    input wire logic timer_shared,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic alt_in
);
    // Segment mode drives the pin; timer output shares it when listed
    always_comb
    begin
        if (select_bit)
        begin
            pin_out = timer_shared ? timer_value : seg_value;
            pin_oe = 1'b1;
        end
        else
        begin
            pin_out = gpio_out;
            pin_oe = gpio_oe;
        end
    end

    // Input functions see the pin only while it is general I/O
    assign alt_in = select_bit ? 1'b0 : pin_in;
endmodule // pin_route

`default_nettype wire

//--- design/port_d_pin_function_select.sv
// Port D pin function select register with AXI4-Lite access and pin routing
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"

module port_d_pin_function_select
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] lcd_segment_output,
    input wire pin_select_pkg::timer_out_t timer_out,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] port_d_pin_in,
    output logic [7:0] port_d_pin_out,
    output logic [7:0] port_d_pin_oe,
    output logic [7:0] gpio_in,
    output pin_select_pkg::timer_in_t timer_in
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] port_d_function_select_ff;
    pin_select_pkg::variant_t variant_ff;
    pin_select_pkg::wr_state_t wr_state_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [11:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [7:0] pin_sync1_ff;
    logic [7:0] pin_sync2_ff;

    logic aw_now;
    logic w_now;
    logic wr_go;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] shared_sel;
    logic [7:0] shared_val;
    logic [7:0] alt_in;
    logic [7:0] pin_out_c;
    logic [7:0] pin_oe_c;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data in either order

    assign aw_now = s_axi_awvalid && s_axi_awready;
    assign w_now = s_axi_wvalid && s_axi_wready;
    assign wr_go = (aw_held_ff || aw_now) && (w_held_ff || w_now) && !s_axi_bvalid;
    assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;

    // Ready only while nothing of that channel is parked
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            if (aw_now)
            begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_now)
            begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            aw_held_ff <= wr_go ? 1'b0 : (aw_held_ff || aw_now);
            w_held_ff <= wr_go ? 1'b0 : (w_held_ff || w_now);
            // Bubble of at least two cycles after each take keeps one write in flight
            s_axi_awready <= !(aw_held_ff || aw_now) && !wr_go && !s_axi_bvalid;
            s_axi_wready <= !(w_held_ff || w_now) && !wr_go && !s_axi_bvalid;
        end
    end

    // Write response state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_ff <= pin_select_pkg::wr_idle;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PDSEL_AXI_OKAY;
        end
        else if (clk_en)
        begin
            case (wr_state_ff)
                pin_select_pkg::wr_idle:
                begin
                    if (wr_go)
                    begin
                        wr_state_ff <= pin_select_pkg::wr_resp;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (wr_addr == `PDSEL_ADDR_SELECT ||
                            wr_addr == `PDSEL_ADDR_VARIANT) ? `PDSEL_AXI_OKAY
                            : `PDSEL_AXI_DECERR;
                    end
                end
                pin_select_pkg::wr_resp:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_ff <= pin_select_pkg::wr_idle;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default:
                begin
                    wr_state_ff <= pin_select_pkg::wr_idle;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Select register, all ones after reset; byte lane 0 only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_d_function_select_ff <= `PDSEL_SELECT_RESET;
            variant_ff <= pin_select_pkg::variant_t'(`PDSEL_VARIANT_RESET);
        end
        else if (clk_en && wr_go && wr_strb[0])
        begin
            if (wr_addr == `PDSEL_ADDR_SELECT)
            begin
                port_d_function_select_ff <= wr_data[7:0];
            end
            if (wr_addr == `PDSEL_ADDR_VARIANT)
            begin
                variant_ff <= pin_select_pkg::variant_t'(wr_data[1:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel, answer one cycle after the address is taken

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PDSEL_AXI_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PDSEL_AXI_OKAY;
                case (s_axi_araddr)
                    `PDSEL_ADDR_SELECT: s_axi_rdata <= {24'h00_0000, port_d_function_select_ff};
                    `PDSEL_ADDR_VARIANT: s_axi_rdata <= {30'h0000_0000, variant_ff};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `PDSEL_AXI_DECERR;
                    end
                endcase
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer output sharing per variant on segment-mode pins

    always_comb
    begin
        shared_sel = 8'h00;
        shared_val = 8'h00;
        // Pins 7..4 carry periodic timer outputs in every variant
        shared_sel[7:4] = 4'hf;
        shared_val[7] = timer_out.periodic_timer1_inverted_output;
        shared_val[6] = timer_out.periodic_timer1_output;
        shared_val[5] = timer_out.periodic_timer0_inverted_output;
        shared_val[4] = timer_out.periodic_timer0_output;
        // Pin 3 is segment alone everywhere
        shared_sel[3] = 1'b0;
        if (variant_ff == pin_select_pkg::variant_small)
        begin
            shared_sel[2] = 1'b1;
            shared_val[2] = timer_out.compact_timer2_output;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin routing, combinational from the registered select bits

    genvar gi;
    generate
        for (gi = 0; gi < `PDSEL_PINS; gi = gi + 1)
        begin : g_pin
            pin_route u_route
            (
                .select_bit(port_d_function_select_ff[gi]),
                .seg_value(lcd_segment_output[gi]),
                .timer_value(shared_val[gi]),
                .timer_shared(shared_sel[gi]),
                .gpio_out(gpio_out[gi]),
                .gpio_oe(gpio_oe[gi]),
                .pin_in(pin_sync2_ff[gi]),
                .pin_out(pin_out_c[gi]),
                .pin_oe(pin_oe_c[gi]),
                .alt_in(alt_in[gi])
            );
        end
    endgenerate

    // Pin inputs pass two flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_sync1_ff <= 8'h00;
            pin_sync2_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            pin_sync1_ff <= port_d_pin_in;
            pin_sync2_ff <= pin_sync1_ff;
        end
    end

    // Registered pin drive; costs one cycle but keeps outputs glitch free
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_d_pin_out <= 8'h00;
            port_d_pin_oe <= 8'h00;
            gpio_in <= 8'h00;
        end
        else if (clk_en)
        begin
            port_d_pin_out <= pin_out_c;
            port_d_pin_oe <= pin_oe_c;
            gpio_in <= alt_in;
        end
    end

    // Shared inputs exist only in the full variant
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_in <= '0;
        end
        else if (clk_en)
        begin
            if (variant_ff == pin_select_pkg::variant_full)
            begin
                timer_in.periodic_timer0_clock_input <= alt_in[3];
                timer_in.standard_timer_clock_input <= alt_in[2];
                timer_in.compact_timer_clock_input <= alt_in[1];
                timer_in.external_interrupt1_input <= alt_in[0];
                timer_in.periodic_timer1_clock_input <= alt_in[0];
            end
            else
            begin
                timer_in <= '0;
            end
        end
    end

endmodule // port_d_pin_function_select

`default_nettype wire

//--- sim/pdsel_props.sv
// Port-level assertions for the port D pin select block
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"

module pdsel_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] port_d_pin_in,
    input wire logic [7:0] gpio_in,
    input wire pin_select_pkg::timer_in_t timer_in
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes hold until taken
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped early");
    a_no_take_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_no_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
        |=> s_axi_rvalid) else $error("read answer late");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_reset_clear: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && gpio_in == 8'h00) else $error("reset state wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs only pass what the pin really shows, three edges late
    a_gpio_source: assert property ($past(clk_en, 1) && $past(clk_en, 2)
        && $past(clk_en, 3) |-> (gpio_in & ~$past(port_d_pin_in, 3)) == 8'h00)
        else $error("gpio_in not from pin");
    a_external_interrupt1_input_pair: assert property (timer_in.external_interrupt1_input ==
        timer_in.periodic_timer1_clock_input) else $error("pin 0 inputs split");
    a_tclk_io: assert property (timer_in.periodic_timer0_clock_input |-> gpio_in[3])
        else $error("timer clock without I/O");

    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == `PDSEL_AXI_DECERR);
    c_tclk: cover property (timer_in != 5'h00);
endmodule // pdsel_props

bind port_d_pin_function_select pdsel_props u_pdsel_props (.aclk, .aresetn, .clk_en,
    .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_d_pin_in, .gpio_in, .timer_in);
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the port D pin select block
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defs.svh"

module tb;
    logic aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] seg, gpio_out, gpio_oe, pin_in, pin_out, pin_oe, gpio_in;
    pin_select_pkg::timer_out_t tmr_out;
    pin_select_pkg::timer_in_t tmr_in;
    int fails, n_tests, cycles;

    port_d_pin_function_select u_port_d_pin_function_select (.aclk, .aresetn, .clk_en,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lcd_segment_output(seg), .timer_out(tmr_out), .gpio_out, .gpio_oe,
        .port_d_pin_in(pin_in), .port_d_pin_out(pin_out), .port_d_pin_oe(pin_oe), .gpio_in,
        .timer_in(tmr_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles: valid held until its own ready, answer taken at the same edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        check({30'h0, bresp}, {30'h0, er}, "bresp");
        // Let one edge pass so a following call never sets bready again in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (arready === 1'h1)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        check(rdata, ed, "rdata");
        check({30'h0, rresp}, {30'h0, er}, "rresp");
        // Same spacing as writes: rready is never reassigned within one step
        @(posedge aclk);
    endtask

    // Wait past the pin flops and the input synchroniser, then compare
    task automatic pins(input logic [7:0] eo, eoe, egi, input logic [4:0] eti);
        repeat (4) @(posedge aclk);
        check({24'h0, pin_out}, {24'h0, eo}, "pin_out");
        check({24'h0, pin_oe}, {24'h0, eoe}, "pin_oe");
        check({24'h0, gpio_in}, {24'h0, egi}, "gpio_in");
        check({27'h0, tmr_in}, {27'h0, eti}, "timer_in");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios; timer outputs 0011 on pins 7..4 differ from segments 1100
    task automatic t_reset();
        rd(`PDSEL_ADDR_SELECT, 32'h0000_00ff, `PDSEL_AXI_OKAY);
        rd(`PDSEL_ADDR_VARIANT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        pins(8'h33, 8'hff, 8'h00, 5'h00);
        $display("test reset done");
    endtask

    task automatic t_io();
        wr(`PDSEL_ADDR_SELECT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        rd(`PDSEL_ADDR_SELECT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        pins(8'ha5, 8'h0a, 8'h96, 5'h0c);
        wr(`PDSEL_ADDR_SELECT, 32'h0000_00f0, `PDSEL_AXI_OKAY);
        pins(8'h35, 8'hfa, 8'h06, 5'h0c);
        $display("test io done");
    endtask

    // Reduced variants: smallest shares pin 2, none feeds timer inputs
    task automatic t_var();
        for (int v = 1; v < 4; v++)
        begin
            wr(`PDSEL_ADDR_VARIANT, 32'(v), `PDSEL_AXI_OKAY);
            rd(`PDSEL_ADDR_VARIANT, 32'(v), `PDSEL_AXI_OKAY);
            wr(`PDSEL_ADDR_SELECT, 32'h0000_00ff, `PDSEL_AXI_OKAY);
            pins((v == 1) ? 8'h37 : 8'h33, 8'hff, 8'h00, 5'h00);
            wr(`PDSEL_ADDR_SELECT, 32'h0000_0000, `PDSEL_AXI_OKAY);
            pins(8'ha5, 8'h0a, 8'h96, 5'h00);
        end
        wr(`PDSEL_ADDR_VARIANT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        $display("test variants done");
    endtask

    // Unmapped place, masked lane, upper bits dropped
    task automatic t_bad();
        wr(12'h008, 32'h0000_00ff, `PDSEL_AXI_DECERR);
        rd(12'h008, 32'h0000_0000, `PDSEL_AXI_DECERR);
        wstrb <= 4'h0;
        wr(`PDSEL_ADDR_SELECT, 32'h0000_0012, `PDSEL_AXI_OKAY);
        wstrb <= 4'hf;
        rd(`PDSEL_ADDR_SELECT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        wr(`PDSEL_ADDR_SELECT, 32'hffff_ff5a, `PDSEL_AXI_OKAY);
        rd(`PDSEL_ADDR_SELECT, 32'h0000_005a, `PDSEL_AXI_OKAY);
        $display("test bad access done");
    endtask

    // Enable low must freeze pin flops and synchroniser; new pin levels land after
    task automatic t_freeze();
        wr(`PDSEL_ADDR_SELECT, 32'h0000_0000, `PDSEL_AXI_OKAY);
        clk_en <= 1'h0;
        pin_in <= 8'h69;
        gpio_out <= 8'h5a;
        pins(8'ha5, 8'h0a, 8'h96, 5'h0c);
        clk_en <= 1'h1;
        pins(8'h5a, 8'h0a, 8'h69, 5'h13);
        $display("test freeze done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {clk_en, wstrb, awaddr, araddr, wdata} = {1'h1, 4'hf, 12'h0, 12'h0, 32'h0};
        {seg, gpio_out, gpio_oe, pin_in} = 32'hc3a5_0a96;
        tmr_out = 5'h07;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_io();
        t_var();
        t_bad();
        t_freeze();
        // Mid-run reset must bring back all ones and the full variant
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        test_done();
    end
endmodule // tb
`default_nettype wire
